// ===== src/pcd_pkg.sv
// Shared constants for the printer character decoder
package pcd_pkg;

  // ****************************************************************
  // Character format
  // ****************************************************************
  localparam int unsigned CODE_W = 7;             // Data bits per char
  localparam int unsigned CHAR_W = CODE_W + 1;    // Data plus parity
  localparam int unsigned BIT_CNT_W = 3;          // Counts 8 serial bits
  localparam logic [2:0]  BIT_LAST = 3'h7;        // Index of parity bit

  // ****************************************************************
  // Column and row fields of a code
  // ****************************************************************
  localparam int unsigned COLUMN_LSB = 4;         // Bits 6..4 = column
  localparam int unsigned ROW_MSB = 3;            // Bits 3..0 = row
  localparam logic [2:0]  COL_CTRL = 3'h0;        // Control column
  localparam logic [2:0]  COL_SPACE = 3'h2;       // Column holding space
  localparam logic [3:0]  ROW_LINE_FEED = 4'ha;
  localparam logic [3:0]  ROW_FORM_FEED = 4'hc;
  localparam logic [3:0]  ROW_CAR_RET = 4'hd;
  localparam logic [3:0]  ROW_SPACE = 4'h0;
  localparam logic [6:0]  DELETE_CODE = 7'h7f;

  // ****************************************************************
  // Font halves of the print wheel
  // ****************************************************************
  localparam logic [6:0]  LEFT_FIRST = 7'h21;     // First left graphic
  localparam logic [6:0]  LEFT_LAST = 7'h5f;      // 63rd left graphic
  localparam logic [6:0]  RIGHT_FIRST = 7'h60;    // First right graphic
  localparam logic [6:0]  RIGHT_LAST = 7'h7e;     // 31st right graphic
  localparam logic [6:0]  LEFT_BIAS = 7'h20;      // Code minus bias = pos
  localparam logic [6:0]  RIGHT_BIAS = 7'h40;     // Right pos 32..62

  // ****************************************************************
  // Carriage and paper pacing
  // ****************************************************************
  localparam logic [7:0]  COL_WRAP = 8'h86;       // 132 columns plus two
  localparam logic [7:0]  COL_RESET = 8'h00;
  localparam int unsigned CLK_PERIOD_NS = 5;
  localparam int unsigned LF_MIN_NS = 33_333_334; // 1/30 s per line
  localparam int unsigned LF_PACE_CYC =
    (LF_MIN_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
  localparam int unsigned FIFO_DEPTH = 4;
  localparam bit          ODD_PARITY = 1'b1;      // Parity sense

  typedef enum logic [1:0] {
    PCD_CLS_IGNORE = 2'b00,
    PCD_CLS_CTRL   = 2'b01,
    PCD_CLS_LEFT   = 2'b10,
    PCD_CLS_RIGHT  = 2'b11
  } pcd_class_t;

  typedef struct packed {
    pcd_class_t cls;
    logic [6:0] pos;
  } pcd_wheel_t;

  // Fixed code to wheel table: font half and sequence position
  function automatic pcd_wheel_t pcd_wheel_lookup(input logic [6:0] code);
    pcd_wheel_t w;
    w.cls = PCD_CLS_IGNORE;
    w.pos = 7'h00;
    if (code >= LEFT_FIRST && code <= LEFT_LAST) begin
      w.cls = PCD_CLS_LEFT;
      w.pos = code - LEFT_BIAS;
    end else if (code >= RIGHT_FIRST && code <= RIGHT_LAST) begin
      w.cls = PCD_CLS_RIGHT;
      w.pos = code - RIGHT_BIAS;
    end
    return w;
  endfunction

endpackage

// ===== src/pcd_stream_if.sv
// Valid/ready character stream between decoder modules
`timescale 1ns/1ps
interface pcd_stream_if #(parameter int unsigned W = 8);
  logic         valid;
  logic         ready;
  logic [W-1:0] data;
  modport src (output valid, output data, input ready);
  modport snk (input valid, input data, output ready);
endinterface

// ===== src/pcd_fifo.sv
// Small character FIFO with valid/ready on both sides
`timescale 1ns/1ps
module pcd_fifo #(
  parameter int unsigned W     = 8,
  parameter int unsigned DEPTH = 4
) (
  input wire logic   clk,    // System clock
  input wire logic   rst_n,  // Async reset, active low
  pcd_stream_if.snk  wr_s,   // Filling side
  pcd_stream_if.src  rd_s    // Draining side
);

  localparam int unsigned AW = $clog2(DEPTH);

  logic [W-1:0] mem [DEPTH];
  logic [AW:0]  wr_ptr;
  logic [AW:0]  rd_ptr;
  logic [AW:0]  next_wr_ptr;
  logic [AW:0]  next_rd_ptr;
  logic         full;
  logic         empty;

  // ****************************************************************
  // Flags from pointers with one wrap bit
  // ****************************************************************
  assign empty = (wr_ptr == rd_ptr);
  assign full  = (wr_ptr[AW] != rd_ptr[AW]) &&
                 (wr_ptr[AW-1:0] == rd_ptr[AW-1:0]);
  assign wr_s.ready = !full;
  assign rd_s.valid = !empty;
  assign rd_s.data  = mem[rd_ptr[AW-1:0]];

  // Pointer advance on handshakes
  always_comb begin
    next_wr_ptr = wr_ptr;
    next_rd_ptr = rd_ptr;
    if (wr_s.valid && !full) begin
      next_wr_ptr = wr_ptr + 1'b1;
    end
    if (rd_s.ready && !empty) begin
      next_rd_ptr = rd_ptr + 1'b1;
    end
  end

  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      wr_ptr <= '0;
      rd_ptr <= '0;
    end else begin
      wr_ptr <= next_wr_ptr;
      rd_ptr <= next_rd_ptr;
    end
  end

  // Storage needs no reset; empty flag hides stale words
  always_ff @(posedge clk) begin
    if (wr_s.valid && !full) begin
      mem[wr_ptr[AW-1:0]] <= wr_s.data;
    end
  end

endmodule

// ===== src/pcd_top.sv
// Character decoder and paper-advance control for the incremental printer
//
// Notes on behaviour
// - Every character is seven code bits plus one parity bit.
// - Top three code bits select column, low four bits select row.
// - LF, FF, CR and space drive controls only, never a hammer strike.
// - Each line feed advances paper exactly one line.
// - Back-to-back line feeds are paced to at most 30 lines per second.
// - Low paper lights forms-end lamp and halts all printing.
// - The 63 uppercase-set graphics go to the left font half.
// - The 31 lowercase-set graphics go to the right font half.
// - Left wheel positions 64 to 72 are never selected.
// - Right wheel positions 1-31 and 63-72 are never selected.
// - Carriage return goes to left margin without moving paper.
// - Passing column 134 forces automatic CR and LF, no error shown.
// - Busy is shown while a character is being received.
`timescale 1ns/1ps
module pcd_top #(
  parameter int unsigned LF_PACE = pcd_pkg::LF_PACE_CYC,
  parameter int unsigned DEPTH   = pcd_pkg::FIFO_DEPTH
) (
  input  wire logic       clk,             // 200 MHz system clock
  input  wire logic       rst_n,           // Async reset, active low
  input  wire logic       ser_sel,         // Printer addressed, pin
  input  wire logic       ser_strobe,      // Bit strobe, rising edge, pin
  input  wire logic       ser_bit,         // Serial data bit, pin
  input  wire logic       forms_low,       // Paper nearly out, pin
  input  wire logic       mech_ready,      // Mechanism idle, pin
  output logic            busy,            // Receiving or cannot accept
  output logic            parity_err,      // Last character bad parity
  output logic            print_go,        // Hammer strike pulse
  output logic            print_right,     // Font half: 1 = right
  output logic [6:0]      print_pos,       // Wheel sequence position
  output logic            lf_go,           // One-line advance pulse
  output logic            cr_go,           // Carriage return pulse
  output logic            ff_go,           // Form feed pulse
  output logic            space_go,        // Carriage step pulse
  output logic            forms_end_lamp   // Forms-end indicator
);

  localparam int unsigned PW = $clog2(LF_PACE + 1);
  localparam logic [PW-1:0] PACE_LOAD = PW'(LF_PACE - 1);

  // ****************************************************************
  // Pin synchronisers
  // ****************************************************************
  logic [4:0] sync_a;
  logic [4:0] sync_b;
  logic       sel_s;
  logic       strobe_s;
  logic       bit_s;
  logic       low_s;
  logic       mrdy_s;
  logic       strobe_d;

  // Two flops each; only the second stage feeds logic
  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      sync_a   <= 5'h00;
      sync_b   <= 5'h00;
      strobe_d <= 1'b0;
    end else begin
      sync_a   <= {ser_sel, ser_strobe, ser_bit, forms_low, mech_ready};
      sync_b   <= sync_a;
      strobe_d <= strobe_s;
    end
  end
  assign {sel_s, strobe_s, bit_s, low_s, mrdy_s} = sync_b;

  // ****************************************************************
  // Serial receiver
  // ****************************************************************
  pcd_stream_if #(.W(pcd_pkg::CHAR_W)) in_s ();
  pcd_stream_if #(.W(pcd_pkg::CHAR_W)) out_s ();

  logic [pcd_pkg::CHAR_W-1:0]    shreg;
  logic [pcd_pkg::CHAR_W-1:0]    next_shreg;
  logic [pcd_pkg::BIT_CNT_W-1:0] bit_cnt;
  logic [pcd_pkg::BIT_CNT_W-1:0] next_bit_cnt;
  logic                          push;
  logic                          next_push;
  logic                          strobe_rise;

  assign strobe_rise = strobe_s && !strobe_d;

  // Shift in LSB first; parity lands in the top bit
  always_comb begin
    next_shreg   = shreg;
    next_bit_cnt = bit_cnt;
    next_push    = push && !in_s.ready;
    if (!sel_s) begin
      next_bit_cnt = '0;
    end else if (strobe_rise && !next_push) begin
      next_shreg   = {bit_s, shreg[pcd_pkg::CHAR_W-1:1]};
      next_bit_cnt = bit_cnt + 1'b1;
      if (bit_cnt == pcd_pkg::BIT_LAST) begin
        next_push = 1'b1;
      end
    end
  end

  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      shreg   <= '0;
      bit_cnt <= '0;
      push    <= 1'b0;
    end else begin
      shreg   <= next_shreg;
      bit_cnt <= next_bit_cnt;
      push    <= next_push;
    end
  end

  assign in_s.valid = push;
  assign in_s.data  = shreg;
  // No character is taken while a word waits for FIFO room
  assign busy = (bit_cnt != '0) || push || !in_s.ready;

  pcd_fifo #(.W(pcd_pkg::CHAR_W), .DEPTH(DEPTH)) u_fifo (
    .clk   (clk),
    .rst_n (rst_n),
    .wr_s  (in_s),
    .rd_s  (out_s)
  );

  // ****************************************************************
  // Decoder and carriage control
  // ****************************************************************
  logic [6:0]          code;
  logic [2:0]          col_idx;
  logic [3:0]          row_idx;
  logic                is_lf;
  logic                is_ff;
  logic                is_cr;
  logic                is_sp;
  logic                par_ok;
  pcd_pkg::pcd_wheel_t wheel;
  logic                pace_idle;
  logic                take;
  logic                fire_auto;
  logic [7:0]          col;
  logic [7:0]          next_col;
  logic [PW-1:0]       pace;
  logic [PW-1:0]       next_pace;
  logic                auto_pend;
  logic                next_auto_pend;
  logic                next_parity_err;
  logic                next_print_go;
  logic                next_print_right;
  logic [6:0]          next_print_pos;
  logic                next_lf_go;
  logic                next_cr_go;
  logic                next_ff_go;
  logic                next_space_go;

  assign code    = out_s.data[pcd_pkg::CODE_W-1:0];
  assign col_idx = code[pcd_pkg::CODE_W-1:pcd_pkg::COLUMN_LSB];
  assign row_idx = code[pcd_pkg::ROW_MSB:0];
  assign is_lf   = (col_idx == pcd_pkg::COL_CTRL) &&
                   (row_idx == pcd_pkg::ROW_LINE_FEED);
  assign is_ff   = (col_idx == pcd_pkg::COL_CTRL) &&
                   (row_idx == pcd_pkg::ROW_FORM_FEED);
  assign is_cr   = (col_idx == pcd_pkg::COL_CTRL) &&
                   (row_idx == pcd_pkg::ROW_CAR_RET);
  assign is_sp   = (col_idx == pcd_pkg::COL_SPACE) &&
                   (row_idx == pcd_pkg::ROW_SPACE);
  assign par_ok  = ((^out_s.data) == pcd_pkg::ODD_PARITY);
  assign wheel   = pcd_pkg::pcd_wheel_lookup(code);
  assign pace_idle = (pace == '0);

  // Low paper freezes both the queue and the automatic wrap
  assign fire_auto = auto_pend && mrdy_s && pace_idle && !low_s;
  // A line feed waits in the queue until pacing lets it through
  assign take = out_s.valid && !auto_pend && mrdy_s && !low_s &&
                (!is_lf || pace_idle);
  assign out_s.ready = take;

  // Each accepted character yields at most one mechanism action
  always_comb begin
    next_col         = col;
    next_pace        = pace_idle ? pace : pace - 1'b1;
    next_auto_pend   = auto_pend;
    next_parity_err  = parity_err;
    next_print_go    = 1'b0;
    next_print_right = print_right;
    next_print_pos   = print_pos;
    next_lf_go       = 1'b0;
    next_cr_go       = 1'b0;
    next_ff_go       = 1'b0;
    next_space_go    = 1'b0;
    if (fire_auto) begin
      next_cr_go     = 1'b1;
      next_lf_go     = 1'b1;
      next_col       = pcd_pkg::COL_RESET;
      next_pace      = PACE_LOAD;
      next_auto_pend = 1'b0;
    end else if (take) begin
      next_parity_err = !par_ok;
      if (!par_ok) begin
        next_col = col;                  // Bad characters are dropped
      end else if (is_lf) begin
        next_lf_go = 1'b1;
        next_pace  = PACE_LOAD;
      end else if (is_cr) begin
        next_cr_go = 1'b1;
        next_col   = pcd_pkg::COL_RESET;
      end else if (is_ff) begin
        next_ff_go = 1'b1;
        next_col   = pcd_pkg::COL_RESET;
      end else if (is_sp) begin
        next_space_go = 1'b1;
        next_col      = col + 1'b1;
      end else begin
        case (wheel.cls)
          pcd_pkg::PCD_CLS_LEFT: begin
            next_print_go    = 1'b1;
            next_print_right = 1'b0;
            next_print_pos   = wheel.pos;
            next_col         = col + 1'b1;
          end
          pcd_pkg::PCD_CLS_RIGHT: begin
            next_print_go    = 1'b1;
            next_print_right = 1'b1;
            next_print_pos   = wheel.pos;
            next_col         = col + 1'b1;
          end
          default: begin
            next_col = col;              // Other controls and delete
          end
        endcase
      end
      if (next_col == pcd_pkg::COL_WRAP) begin
        next_auto_pend = 1'b1;
      end
    end
  end

  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      col            <= pcd_pkg::COL_RESET;
      pace           <= '0;
      auto_pend      <= 1'b0;
      parity_err     <= 1'b0;
      print_go       <= 1'b0;
      print_right    <= 1'b0;
      print_pos      <= 7'h00;
      lf_go          <= 1'b0;
      cr_go          <= 1'b0;
      ff_go          <= 1'b0;
      space_go       <= 1'b0;
      forms_end_lamp <= 1'b0;
    end else begin
      col            <= next_col;
      pace           <= next_pace;
      auto_pend      <= next_auto_pend;
      parity_err     <= next_parity_err;
      print_go       <= next_print_go;
      print_right    <= next_print_right;
      print_pos      <= next_print_pos;
      lf_go          <= next_lf_go;
      cr_go          <= next_cr_go;
      ff_go          <= next_ff_go;
      space_go       <= next_space_go;
      forms_end_lamp <= low_s;
    end
  end

endmodule

// ===== verif/pcd_sender.sv
// Console-side serial sender model feeding the decoder pins
`timescale 1ns/1ps
module pcd_sender (
  input  wire logic clk,        // System clock
  output logic      ser_sel,    // Printer addressed
  output logic      ser_strobe, // Bit strobe
  output logic      ser_bit     // Serial data bit
);
  // Lines idle low until the first character
  initial begin
    ser_sel = 1'b0;
    ser_strobe = 1'b0;
    ser_bit = 1'b0;
  end

  // Four-cycle strobe phases stay clear of the three-cycle minimum
  // Fewer than eight bits models a transfer abandoned by the console
  task automatic send(input logic [6:0] code, input logic bad,
                      input int nbits = 8);
    logic [7:0] w;
    w = {~^code ^ bad, code};
    @(posedge clk);
    #1 ser_sel = 1'b1;
    for (int i = 0; i < nbits; i++) begin
      ser_bit = w[i];
      repeat (4) @(posedge clk);
      #1 ser_strobe = 1'b1;
      repeat (4) @(posedge clk);
      #1 ser_strobe = 1'b0;
    end
    repeat (8) @(posedge clk);
    #1 ser_sel = 1'b0;
    ser_bit = ~ser_bit; // Released line must not echo stale data
  endtask
endmodule

// ===== verif/pcd_top_asserts.sv
// Port-level checker for the printer character decoder
`timescale 1ns/1ps
module pcd_top_asserts #(
  parameter int unsigned LF_PACE = 20
) (
  input wire logic       clk,            // System clock
  input wire logic       rst_n,          // Async reset, active low
  input wire logic       ser_sel,        // Printer addressed
  input wire logic       ser_strobe,     // Bit strobe
  input wire logic       ser_bit,        // Serial data bit
  input wire logic       forms_low,      // Paper nearly out
  input wire logic       mech_ready,     // Mechanism idle
  input wire logic       busy,           // Receiving or full
  input wire logic       parity_err,     // Bad parity seen
  input wire logic       print_go,       // Hammer strike
  input wire logic       print_right,    // Font half
  input wire logic [6:0] print_pos,      // Wheel position
  input wire logic       lf_go,          // Line advance
  input wire logic       cr_go,          // Carriage return
  input wire logic       ff_go,          // Form feed
  input wire logic       space_go,       // Carriage step
  input wire logic       forms_end_lamp  // Forms-end lamp
);
  // ****************************************************************
  // Line feed spacing
  // ****************************************************************
  int unsigned gap;
  int unsigned next_gap;
  wire         any_ctl = lf_go | cr_go | ff_go | space_go;

  // Saturates so a long idle spell cannot wrap round
  always_comb begin
    next_gap = gap;
    if (lf_go) next_gap = 1;
    else if (gap < LF_PACE) next_gap = gap + 1;
  end

  // Starts saturated: the first feed after reset is never early
  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) gap <= LF_PACE;
    else gap <= next_gap;
  end

  default clocking cb @(posedge clk); endclocking
  default disable iff (!rst_n);

  sequence s_bit_in;
    $rose(ser_strobe) && ser_sel && !busy;
  endsequence
  sequence s_lamp_held;
    forms_end_lamp && $past(forms_end_lamp);
  endsequence

  property p_busy_rise;
    s_bit_in |-> ##[2:5] busy;
  endproperty
  property p_ctl_no_strike;
    print_go |-> !any_ctl;
  endproperty
  property p_left_pos;
    print_go && !print_right |-> print_pos inside {[7'h01:7'h3f]};
  endproperty
  property p_right_pos;
    print_go && print_right |-> print_pos inside {[7'h20:7'h3e]};
  endproperty
  property p_lf_pace;
    lf_go |-> gap >= LF_PACE;
  endproperty
  property p_lamp_on;
    $rose(forms_low) |-> ##[1:4] forms_end_lamp;
  endproperty
  property p_lamp_halt;
    s_lamp_held |-> !print_go && !any_ctl;
  endproperty
  property p_parity_drop;
    $rose(parity_err) |-> !print_go && !any_ctl;
  endproperty

  a_busy_rise: assert property (p_busy_rise)
    else $error("busy did not rise after a bit");
  a_ctl_no_strike: assert property (p_ctl_no_strike)
    else $error("strike together with a control action");
  a_left_pos: assert property (p_left_pos)
    else $error("left font position out of range");
  a_right_pos: assert property (p_right_pos)
    else $error("right font position out of range");
  a_lf_pace: assert property (p_lf_pace)
    else $error("line feeds too close together");
  a_lamp_on: assert property (p_lamp_on)
    else $error("forms-end lamp late");
  a_lamp_halt: assert property (p_lamp_halt)
    else $error("action while forms end is lit");
  a_parity_drop: assert property (p_parity_drop)
    else $error("bad parity character acted on");
endmodule

bind pcd_top pcd_top_asserts #(.LF_PACE(LF_PACE)) u_pcd_top_asserts (
  .clk(clk), .rst_n(rst_n), .ser_sel(ser_sel), .ser_strobe(ser_strobe),
  .ser_bit(ser_bit), .forms_low(forms_low), .mech_ready(mech_ready),
  .busy(busy), .parity_err(parity_err), .print_go(print_go),
  .print_right(print_right), .print_pos(print_pos), .lf_go(lf_go),
  .cr_go(cr_go), .ff_go(ff_go), .space_go(space_go),
  .forms_end_lamp(forms_end_lamp)
);

// ===== verif/test_printer_character_decoder.sv
// Self-checking bench for the printer character decoder
`timescale 1ns/1ps
module test_printer_character_decoder;
  localparam int unsigned PACE = 200; // Short stand-in for 1/30 s
  logic       clk, rst_n, ser_sel, ser_strobe, ser_bit;
  logic       forms_low, mech_ready, busy, parity_err, print_go;
  logic       print_right, lf_go, cr_go, ff_go, space_go, forms_end_lamp;
  logic [6:0] print_pos;
  int         error_cnt = 0, samples_checked = 0, cyc = 0;
  int         last_lf = -100000, min_gap = 1 << 30;
  int         cnt [6] = '{default: 0}; // Strike, lf, cr, ff, sp, cr+lf
  logic [7:0] strikes [$];             // Font half and position

  pcd_top #(.LF_PACE(PACE)) u_pcd_top (
    .clk(clk), .rst_n(rst_n), .ser_sel(ser_sel), .ser_strobe(ser_strobe),
    .ser_bit(ser_bit), .forms_low(forms_low), .mech_ready(mech_ready),
    .busy(busy), .parity_err(parity_err), .print_go(print_go),
    .print_right(print_right), .print_pos(print_pos), .lf_go(lf_go),
    .cr_go(cr_go), .ff_go(ff_go), .space_go(space_go),
    .forms_end_lamp(forms_end_lamp));
  pcd_sender u_pcd_sender (.clk(clk), .ser_sel(ser_sel),
    .ser_strobe(ser_strobe), .ser_bit(ser_bit));

  // 200 MHz clock
  initial begin
    clk = 1'b0;
    forever #2.5 clk = ~clk;
  end

  // Tally every mechanism pulse so scenarios compare deltas
  always @(posedge clk) begin
    cyc++;
    if (print_go === 1'b1) begin
      cnt[0]++;
      strikes.push_back({print_right, print_pos});
    end
    if (lf_go === 1'b1) begin
      cnt[1]++;
      if (cyc - last_lf < min_gap) min_gap = cyc - last_lf;
      last_lf = cyc;
    end
    cnt[2] += (cr_go === 1'b1);
    cnt[3] += (ff_go === 1'b1);
    cnt[4] += (space_go === 1'b1);
    cnt[5] += (cr_go === 1'b1 && lf_go === 1'b1);
  end

  // ****************************************************************
  // Shared helpers
  // ****************************************************************
  task automatic check(input logic [31:0] seen, input logic [31:0] exp);
    samples_checked++;
    if (seen !== exp) begin
      error_cnt++;
      $display("unexpected at %0t: saw %0h want %0h", $time, seen, exp);
    end
  endtask

  task automatic results();
    if (error_cnt == 0 && samples_checked > 0) $display("TEST PASSED");
    else $display("TEST FAILED");
    $finish;
  endtask

  // Index 6 waits for busy low, others for a pulse count
  task automatic wait_until(input int idx, input int target);
    int n;
    n = 0;
    while (idx == 6 ? busy !== 1'b0 : cnt[idx] < target) begin
      @(posedge clk);
      n++;
      if (n > 3000) begin
        check(1, 0);
        results();
      end
    end
  endtask

  // Only start a character once the block is ready for it
  task automatic tx(input logic [6:0] code, input logic bad = 1'b0);
    wait_until(6, 0);
    u_pcd_sender.send(code, bad);
  endtask

  // ****************************************************************
  // Scenarios
  // ****************************************************************
  task automatic t_controls();
    int b [6];
    b = cnt;
    tx(7'h0a);
    tx(7'h0c);
    tx(7'h0d);
    tx(7'h20);
    wait_until(4, b[4] + 1);
    repeat (30) @(posedge clk);
    check(cnt[1] - b[1], 1);
    check(cnt[2] - b[2], 1);
    check(cnt[3] - b[3], 1);
    check(cnt[0] - b[0], 0);
  endtask

  // Both ends of each font half, plus codes that must be ignored
  task automatic t_graphics();
    logic [6:0] code [8];
    code = '{7'h21, 7'h41, 7'h5f, 7'h60, 7'h7a, 7'h7e, 7'h7f, 7'h01};
    strikes.delete();
    foreach (code[i]) tx(code[i]);
    repeat (40) @(posedge clk);
    check(strikes.size(), 6);
    for (int i = 0; i < 6 && i < strikes.size(); i++)
      check(strikes[i], code[i] < 7'h60 ? {1'b0, code[i] - 7'h20} :
            {1'b1, code[i] - 7'h40});
  endtask

  task automatic t_parity();
    int b0;
    b0 = cnt[0];
    tx(7'h41, 1'b1);
    repeat (30) @(posedge clk);
    check(parity_err, 1);
    check(cnt[0] - b0, 0);
    tx(7'h42);
    wait_until(0, b0 + 1);
    check(parity_err, 0);
  endtask

  task automatic t_pace();
    int b1;
    b1 = cnt[1];
    min_gap = 1 << 30;
    repeat (3) tx(7'h0a);
    wait_until(1, b1 + 3);
    check(min_gap >= PACE, 1);
    check(cnt[1] - b1, 3);
  endtask

  // Stalled mechanism: fill the queue until it refuses, then drain
  task automatic t_fill();
    int b0;
    b0 = cnt[0];
    @(posedge clk);
    #1 mech_ready = 1'b0;
    for (int i = 0; i < 4; i++) tx(7'(7'h30 + i));
    repeat (10) @(posedge clk);
    check(busy, 1);
    check(cnt[0] - b0, 0);
    #1 mech_ready = 1'b1;
    wait_until(0, b0 + 4);
    repeat (5) @(posedge clk);
    check(busy, 0);
  endtask

  // Dropping the address mid character discards the partial bits
  task automatic t_abort();
    int b0;
    b0 = cnt[0];
    strikes.delete();
    u_pcd_sender.send(7'h41, 1'b0, 3);
    repeat (5) @(posedge clk);
    check(busy, 0);
    tx(7'h42);
    wait_until(0, b0 + 1);
    repeat (5) @(posedge clk);
    check(strikes.size(), 1);
    check(strikes.size() > 0 ? strikes[0] : 8'hff, 8'h22);
  endtask

  task automatic t_forms();
    int b0;
    b0 = cnt[0];
    @(posedge clk);
    #1 forms_low = 1'b1;
    tx(7'h42);
    repeat (40) @(posedge clk);
    check(forms_end_lamp, 1);
    check(cnt[0] - b0, 0);
    #1 forms_low = 1'b0;
    wait_until(0, b0 + 1);
    check(forms_end_lamp, 0);
  endtask

  // Past 132 columns plus two the carriage wraps by itself
  task automatic t_wrap();
    int b [6];
    tx(7'h0d);
    b = cnt;
    repeat (134) tx(7'h20);
    wait_until(5, b[5] + 1);
    repeat (30) @(posedge clk);
    check(cnt[5] - b[5], 1);
    check(cnt[4] - b[4], 134);
    check(parity_err, 0);
  endtask

  // Main sequence
  initial begin
    rst_n = 1'b0;
    forms_low = 1'b0;
    mech_ready = 1'b1;
    repeat (20) @(posedge clk);
    #1 rst_n = 1'b1;
    repeat (5) @(posedge clk);
    t_controls();
    t_graphics();
    t_parity();
    t_abort();
    t_pace();
    t_fill();
    t_forms();
    t_wrap();
    results();
  end
endmodule
